// ---- core/ifa_pkg.sv ----
/*
 constants and carrier types for the add-family execution unit.
 assumes a 64-bit core feeding operands, instruction word and pc over apb.
*/
//
// Overview of operation
// (RULE1) special opcode, funct 100000, shamt zero: trapping sum
// (RULE2) 33-bit sum; bit32 != bit31 traps overflow
// (RULE3) no overflow: sign-extended low word to rd
// (RULE4) software keeps operand bits 63..31 equal
// (RULE5) float opcode, funct zero: float sum; fmt selects
// (RULE6) exact sum, rounded per current rounding mode
// (RULE7) paired halves added apart, causes ored
// (RULE8) no exception taken: cause ored into flags
// (RULE9) software names valid registers holding fmt values
// (RULE10) paired result defined only in 64-bit mode
// (RULE11) release 6 rejects the paired float sum
// (RULE12) float sum raises unusable or reserved exceptions
// (RULE13) signal unimplemented, invalid, inexact, overflow, underflow
// (RULE14) opcode 001000: immediate sum, overflow traps, rt kept
// (RULE15) no overflow: sign-extended low word to rt
// (RULE16) release 6 rejects the trapping immediate sum
// (RULE17) opcode 001001: wrapping immediate sum into rt
// (RULE18) wrapping immediate sum never traps
// (RULE19) opcode 111011, minor 00: pc-relative, release 6
// (RULE20) pc plus shifted sign-extended immediate into rs
// (RULE21) sign-extend pc sum like virtual addresses
// (RULE22) unknown format code is a reserved instruction
package ifa_pkg;
   localparam logic [7:0] ADDR_INSN = 8'h00;
   localparam logic [7:0] ADDR_PC_LO = 8'h04;
   localparam logic [7:0] ADDR_PC_HI = 8'h08;
   localparam logic [7:0] ADDR_A_LO = 8'h0c;
   localparam logic [7:0] ADDR_A_HI = 8'h10;
   localparam logic [7:0] ADDR_B_LO = 8'h14;
   localparam logic [7:0] ADDR_B_HI = 8'h18;
   localparam logic [7:0] ADDR_CFG = 8'h1c;
   localparam logic [7:0] ADDR_FCS = 8'h20;
   localparam logic [7:0] ADDR_RES_LO = 8'h24;
   localparam logic [7:0] ADDR_RES_HI = 8'h28;
   localparam logic [7:0] ADDR_STAT = 8'h2c;

   localparam logic [5:0] OP_SPECIAL = 6'h00;
   localparam logic [5:0] FN_SUM_TRAP = 6'h20;
   localparam logic [5:0] FN_SUM_WRAP = 6'h21;
   localparam logic [5:0] OP_FLOAT = 6'h11;
   localparam logic [5:0] FN_FSUM = 6'h00;
   localparam logic [5:0] OP_IMM_TRAP = 6'h08;
   localparam logic [5:0] OP_IMM_WRAP = 6'h09;
   localparam logic [5:0] OP_PC_REL = 6'h3b;
   localparam logic [1:0] PC_REL_MINOR = 2'h0;
   localparam logic [4:0] FMT_S = 5'h10;
   localparam logic [4:0] FMT_D = 5'h11;
   localparam logic [4:0] FMT_PS = 5'h16;

   localparam logic [1:0] RM_NEAR = 2'h0;
   localparam logic [1:0] RM_ZERO = 2'h1;
   localparam logic [1:0] RM_UP = 2'h2;
   localparam logic [1:0] RM_DOWN = 2'h3;

   localparam int C_I = 0;
   localparam int C_U = 1;
   localparam int C_O = 2;
   localparam int C_V = 4;
   localparam int C_E = 5;

   typedef enum logic [2:0] {
      EXC_NONE = 3'h0,
      EXC_INT_OVF = 3'h1,
      EXC_RESERVED = 3'h2,
      EXC_UNUSABLE = 3'h3,
      EXC_FLOAT = 3'h4
   } ifa_exc_e;

   typedef struct packed {
      logic addr64;
      logic fr64;
      logic fpuEn;
      logic rel6;
   } ifa_cfg_s;

   typedef struct packed {
      logic [5:0] cause;
      logic [4:0] enables;
      logic [4:0] flags;
      logic [1:0] rm;
   } ifa_fcs_s;

   typedef struct packed {
      logic [4:0] dst;
      ifa_exc_e exc;
      logic wFlt;
      logic wGen;
   } ifa_stat_s;

   localparam logic [3:0] CFG_RST = 4'he;
   localparam logic [17:0] FCS_RST = 18'h0;
   localparam logic [9:0] STAT_RST = 10'h0;
endpackage : ifa_pkg

// ---- core/ifa_add_unit.sv ----
/*
 add-family execution unit: integer word sums, immediate sums,
 pc-relative sum and float sum in single, double and paired formats.
 assumes an apb master on clk; the pipeline writes back from status.
*/
`timescale 1ns/1ps

module ifa_fp_adder #(
   parameter int EW = 8,
   parameter int MW = 23
) (
   input wire logic [EW+MW:0] a,
   input wire logic [EW+MW:0] b,
   input wire logic [1:0] rm,
   output logic [EW+MW:0] y,
   output logic [5:0] cause
);
   localparam int W = MW + 5;
   localparam logic [EW-1:0] EMAX = '1;
   logic sa, sb, sL, sub, nanA, nanB, infA, infB, sig, lost, inc, rs;
   logic [EW-1:0] ea, eb, eL, eS;
   logic [MW-1:0] ma, mb, mL, mS, frac;
   logic [W-1:0] fL, fS, al, sum, nrm;
   logic [EW:0] d;
   logic [MW+1:0] rnd;
   logic signed [EW+1:0] ex;
   int lz;

   always_comb begin
      y = '0;
      cause = '0;
      {sa, ea, ma} = a;
      {sb, eb, mb} = b;
      nanA = ea == EMAX && ma != '0;
      nanB = eb == EMAX && mb != '0;
      infA = ea == EMAX && ma == '0;
      infB = eb == EMAX && mb == '0;
      sig = (nanA && !ma[MW-1]) || (nanB && !mb[MW-1]);
      sub = sa ^ sb;
      // larger magnitude first, exact align with sticky
      if ({ea, ma} >= {eb, mb}) begin
         {sL, eL, mL, eS, mS} = {sa, ea, ma, eb, mb};
      end else begin
         {sL, eL, mL, eS, mS} = {sb, eb, mb, ea, ma};
      end
      fL = {1'b0, eL != '0, mL, 3'h0};
      fS = {1'b0, eS != '0, mS, 3'h0};
      d = {1'b0, eL} - {1'b0, eS};
      al = fS >> d;
      lost = (al << d) != fS;
      al[0] = al[0] | lost;
      sum = sub ? fL - al : fL + al;
      ex = (EW+2)'({2'h0, eL});
      lz = W - 1;
      for (int i = 0; i < W - 1; i++) begin
         if (sum[i]) begin
            lz = W - 2 - i;
         end
      end
      if (sum[W-1]) begin
         nrm = {1'b0, sum[W-1:2], sum[1] | sum[0]};
         ex = ex + (EW+2)'(1);
      end else begin
         nrm = sum << lz;
         ex = ex - (EW+2)'(lz);
      end
      // round by mode (RULE6)
      rs = nrm[1] | nrm[0];
      case (rm)
         ifa_pkg::RM_NEAR: inc = nrm[2] & (rs | nrm[3]);
         ifa_pkg::RM_UP: inc = !sL & (nrm[2] | rs);
         ifa_pkg::RM_DOWN: inc = sL & (nrm[2] | rs);
         default: inc = 1'b0;
      endcase
      rnd = {1'b0, nrm[W-2:3]} + (MW+2)'(inc);
      frac = rnd[MW-1:0];
      if (rnd[MW+1]) begin
         ex = ex + (EW+2)'(1);
         frac = '0;
      end
      if (nanA || nanB || (infA && infB && sub)) begin
         y = {1'b0, EMAX, 1'b1, (MW-1)'(0)};
         cause[ifa_pkg::C_V] = sig || (infA && infB && sub); // RULE13
      end else if (infA || infB) begin
         y = infA ? a : b;
      end else if ((ea == '0 && ma != '0) || (eb == '0 && mb != '0)) begin
         cause[ifa_pkg::C_E] = 1'b1; // RULE13
      end else if (sum == '0) begin
         y = {sub ? rm == ifa_pkg::RM_DOWN : sa, (EW+MW)'(0)};
      end else if (ex <= 0) begin
         y = {sL, (EW+MW)'(0)};
         cause[ifa_pkg::C_U] = 1'b1; // RULE13
         cause[ifa_pkg::C_I] = 1'b1;
      end else if (ex >= $signed({2'h0, EMAX})) begin
         cause[ifa_pkg::C_O] = 1'b1; // RULE13
         cause[ifa_pkg::C_I] = 1'b1;
         if (rm == ifa_pkg::RM_ZERO || (rm == ifa_pkg::RM_UP && sL)
             || (rm == ifa_pkg::RM_DOWN && !sL)) begin
            y = {sL, EMAX - EW'(1), {MW{1'b1}}};
         end else begin
            y = {sL, EMAX, (MW)'(0)};
         end
      end else begin
         y = {sL, ex[EW-1:0], frac};
         cause[ifa_pkg::C_I] = nrm[2] | rs; // RULE13
      end
   end
endmodule : ifa_fp_adder

module ifa_add_unit (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   logic [63:0] pcQ, pcD, opAQ, opAD, opBQ, opBD, resQ, resD;
   ifa_pkg::ifa_cfg_s cfgQ, cfgD;
   ifa_pkg::ifa_fcs_s fcsQ, fcsD;
   ifa_pkg::ifa_stat_s statQ, statD;
   logic [31:0] prdataQ, prdataD;
   logic preadyQ, preadyD, pslverrQ, pslverrD;
   logic wrAcc, execGo, ovfW, ovfI, taken;
   logic [31:0] w;
   logic [5:0] op, fn;
   logic [4:0] fmt;
   logic [32:0] sumW, sumI;
   logic [63:0] sumWExt, sumIExt, pcSum, pcRes;
   logic [31:0] ySLo, yPHi;
   logic [63:0] yD, yF;
   logic [5:0] cS, cP, cD, cs;
   logic [4:0] flagsOr;
   logic fmtOk;

   // two singles share one width, one double
   ifa_fp_adder #(.EW(8), .MW(23)) uLo (
      .a(opAQ[31:0]), .b(opBQ[31:0]), .rm(fcsQ.rm), .y(ySLo), .cause(cS)
   );
   ifa_fp_adder #(.EW(8), .MW(23)) uHi ( // RULE7
      .a(opAQ[63:32]), .b(opBQ[63:32]), .rm(fcsQ.rm), .y(yPHi), .cause(cP)
   );
   ifa_fp_adder #(.EW(11), .MW(52)) uDbl (
      .a(opAQ), .b(opBQ), .rm(fcsQ.rm), .y(yD), .cause(cD)
   );

   assign prdata = prdataQ;
   assign pready = preadyQ;
   assign pslverr = pslverrQ;

   always_comb begin
      w = pwdata;
      op = w[31:26];
      fn = w[5:0];
      fmt = w[25:21];
      sumW = {opAQ[31], opAQ[31:0]} + {opBQ[31], opBQ[31:0]}; // RULE2
      ovfW = sumW[32] != sumW[31]; // RULE2
      sumWExt = {{32{sumW[31]}}, sumW[31:0]}; // RULE3
      sumI = {opAQ[31], opAQ[31:0]} + {{17{w[15]}}, w[15:0]}; // RULE14
      ovfI = sumI[32] != sumI[31]; // RULE14
      sumIExt = {{32{sumI[31]}}, sumI[31:0]}; // RULE15 RULE17
      pcSum = pcQ + {{43{w[18]}}, w[18:0], 2'h0}; // RULE20
      pcRes = cfgQ.addr64 ? pcSum : {{32{pcSum[31]}}, pcSum[31:0]}; // RULE21
      fmtOk = 1'b1;
      case (fmt) // RULE22
         ifa_pkg::FMT_S: begin
            cs = cS;
            yF = {32'h0, ySLo};
         end
         ifa_pkg::FMT_D: begin
            cs = cD;
            yF = yD;
         end
         ifa_pkg::FMT_PS: begin
            cs = cS | cP; // RULE7
            yF = {yPHi, ySLo};
            fmtOk = !cfgQ.rel6; // RULE11
         end
         default: begin
            cs = '0;
            yF = '0;
            fmtOk = 1'b0;
         end
      endcase
      taken = cs[ifa_pkg::C_E] || (cs[4:0] & fcsQ.enables) != '0;
      flagsOr = fcsQ.flags | cs[4:0];
   end

   always_comb begin
      pcD = pcQ;
      opAD = opAQ;
      opBD = opBQ;
      resD = resQ;
      cfgD = cfgQ;
      fcsD = fcsQ;
      statD = statQ;
      prdataD = '0;
      pslverrD = 1'b0;
      preadyD = psel && !penable;
      wrAcc = psel && penable && preadyQ && pwrite && !pslverrQ;
      execGo = wrAcc && paddr == ifa_pkg::ADDR_INSN;
      if (psel && !penable) begin
         case (paddr)
            ifa_pkg::ADDR_INSN: prdataD = '0;
            ifa_pkg::ADDR_PC_LO: prdataD = pcQ[31:0];
            ifa_pkg::ADDR_PC_HI: prdataD = pcQ[63:32];
            ifa_pkg::ADDR_A_LO: prdataD = opAQ[31:0];
            ifa_pkg::ADDR_A_HI: prdataD = opAQ[63:32];
            ifa_pkg::ADDR_B_LO: prdataD = opBQ[31:0];
            ifa_pkg::ADDR_B_HI: prdataD = opBQ[63:32];
            ifa_pkg::ADDR_CFG: prdataD = {28'h0, cfgQ};
            ifa_pkg::ADDR_FCS: prdataD = {14'h0, fcsQ};
            ifa_pkg::ADDR_RES_LO: prdataD = resQ[31:0];
            ifa_pkg::ADDR_RES_HI: prdataD = resQ[63:32];
            ifa_pkg::ADDR_STAT: prdataD = {22'h0, statQ};
            default: pslverrD = 1'b1;
         endcase
      end
      if (wrAcc) begin
         case (paddr)
            ifa_pkg::ADDR_PC_LO: pcD[31:0] = pwdata;
            ifa_pkg::ADDR_PC_HI: pcD[63:32] = pwdata;
            ifa_pkg::ADDR_A_LO: opAD[31:0] = pwdata;
            ifa_pkg::ADDR_A_HI: opAD[63:32] = pwdata;
            ifa_pkg::ADDR_B_LO: opBD[31:0] = pwdata;
            ifa_pkg::ADDR_B_HI: opBD[63:32] = pwdata;
            ifa_pkg::ADDR_CFG: cfgD = pwdata[3:0];
            ifa_pkg::ADDR_FCS: fcsD = pwdata[17:0];
            default: ;
         endcase
      end
      if (execGo) begin
         statD = '0;
         statD.exc = ifa_pkg::EXC_RESERVED;
         case (op)
            ifa_pkg::OP_SPECIAL: begin
               statD.dst = w[15:11];
               if (fn == ifa_pkg::FN_SUM_TRAP && w[10:6] == '0) begin // RULE1
                  if (ovfW) begin
                     statD.exc = ifa_pkg::EXC_INT_OVF; // RULE2
                  end else begin
                     statD.exc = ifa_pkg::EXC_NONE;
                     statD.wGen = 1'b1;
                     resD = sumWExt; // RULE3
                  end
               end else if (fn == ifa_pkg::FN_SUM_WRAP && w[10:6] == '0) begin
                  statD.exc = ifa_pkg::EXC_NONE;
                  statD.wGen = 1'b1;
                  resD = sumWExt;
               end
            end
            ifa_pkg::OP_IMM_TRAP: begin
               statD.dst = w[20:16];
               if (!cfgQ.rel6) begin // RULE16
                  if (ovfI) begin
                     statD.exc = ifa_pkg::EXC_INT_OVF; // RULE14
                  end else begin
                     statD.exc = ifa_pkg::EXC_NONE;
                     statD.wGen = 1'b1;
                     resD = sumIExt; // RULE15
                  end
               end
            end
            ifa_pkg::OP_IMM_WRAP: begin
               statD.dst = w[20:16];
               statD.exc = ifa_pkg::EXC_NONE; // RULE18
               statD.wGen = 1'b1;
               resD = sumIExt; // RULE17
            end
            ifa_pkg::OP_PC_REL: begin
               statD.dst = w[25:21];
               if (cfgQ.rel6 && w[20:19] == ifa_pkg::PC_REL_MINOR) begin // RULE19
                  statD.exc = ifa_pkg::EXC_NONE;
                  statD.wGen = 1'b1;
                  resD = pcRes; // RULE20
               end
            end
            ifa_pkg::OP_FLOAT: begin
               statD.dst = w[10:6];
               if (!cfgQ.fpuEn) begin
                  statD.exc = ifa_pkg::EXC_UNUSABLE; // RULE12
               end else if (fn == ifa_pkg::FN_FSUM && fmtOk) begin // RULE5
                  fcsD.cause = cs; // RULE13
                  if (taken) begin
                     statD.exc = ifa_pkg::EXC_FLOAT;
                  end else begin
                     statD.exc = ifa_pkg::EXC_NONE;
                     statD.wFlt = 1'b1;
                     fcsD.flags = flagsOr; // RULE8
                     resD = yF; // RULE6 RULE10
                  end
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pcQ <= 64'h0;
         opAQ <= 64'h0;
         opBQ <= 64'h0;
         resQ <= 64'h0;
         cfgQ <= ifa_pkg::CFG_RST;
         fcsQ <= ifa_pkg::FCS_RST;
         statQ <= ifa_pkg::STAT_RST;
         prdataQ <= 32'h0;
         preadyQ <= 1'b0;
         pslverrQ <= 1'b0;
      end else begin
         pcQ <= pcD;
         opAQ <= opAD;
         opBQ <= opBD;
         resQ <= resD;
         cfgQ <= cfgD;
         fcsQ <= fcsD;
         statQ <= statD;
         prdataQ <= prdataD;
         preadyQ <= preadyD;
         pslverrQ <= pslverrD;
      end
   end

   ovf_trap_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
      execGo && op == ifa_pkg::OP_SPECIAL && fn == ifa_pkg::FN_SUM_TRAP
      && w[10:6] == '0 && ovfW |=> statQ.exc == ifa_pkg::EXC_INT_OVF
      && !statQ.wGen && resQ == $past(resQ))
      else $error("trapping sum overflow not signalled");

   word_result_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
      execGo && op == ifa_pkg::OP_SPECIAL && fn == ifa_pkg::FN_SUM_TRAP
      && w[10:6] == '0 && !ovfW |=> statQ.wGen && resQ == $past(sumWExt))
      else $error("trapping sum result wrong");

   wrap_noovf_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
      execGo && op == ifa_pkg::OP_IMM_WRAP
      |=> statQ.exc == ifa_pkg::EXC_NONE && statQ.dst == $past(w[20:16]))
      else $error("wrapping immediate sum trapped");

   imm_rel6_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
      execGo && op == ifa_pkg::OP_IMM_TRAP && cfgQ.rel6
      |=> statQ.exc == ifa_pkg::EXC_RESERVED && !statQ.wGen)
      else $error("trapping immediate sum accepted in release 6");

   ps_rel6_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
      execGo && op == ifa_pkg::OP_FLOAT && cfgQ.fpuEn && cfgQ.rel6
      && fmt == ifa_pkg::FMT_PS |=> statQ.exc == ifa_pkg::EXC_RESERVED)
      else $error("paired sum accepted in release 6");

   fpu_off_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
      execGo && op == ifa_pkg::OP_FLOAT && !cfgQ.fpuEn
      |=> statQ.exc == ifa_pkg::EXC_UNUSABLE && $stable(fcsQ))
      else $error("unusable float unit not signalled");

   flag_accum_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
      execGo && op == ifa_pkg::OP_FLOAT && cfgQ.fpuEn && fn == ifa_pkg::FN_FSUM
      && fmtOk && !taken |=> fcsQ.flags == $past(flagsOr) && statQ.wFlt)
      else $error("flags not accumulated");

   pc_rel_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE20
      execGo && op == ifa_pkg::OP_PC_REL && cfgQ.rel6 && w[20:19] == 2'h0
      |=> resQ == $past(pcRes) && statQ.dst == $past(w[25:21]))
      else $error("pc-relative sum wrong");

   bad_fmt_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE22
      execGo && op == ifa_pkg::OP_FLOAT && cfgQ.fpuEn && !fmtOk
      |=> statQ.exc == ifa_pkg::EXC_RESERVED && !statQ.wFlt)
      else $error("bad format not reserved");
endmodule : ifa_add_unit

// ---- verification/ifa_apb_master.sv ----
/*
 apb master standing in for the decode and issue pipeline.
 assumes the bench raises start for one cycle and waits for done.
*/
`timescale 1ns/1ps

module ifa_apb_master (
   input wire logic clk,
   input wire logic start,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   output logic done,
   output logic [31:0] rdata,
   output logic err,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      done = 1'b0;
      rdata = 32'h0;
      err = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // setup, access held until pready, then release
   always @(posedge clk) begin
      done <= 1'b0;
      if (psel && penable) begin
         if (pready) begin
            rdata <= prdata;
            err <= pslverr;
            done <= 1'b1;
            psel <= 1'b0;
            penable <= 1'b0;
            pwdata <= ~pwdata;
         end
      end else if (psel) begin
         penable <= 1'b1;
      end else if (start) begin
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= addr;
         pwdata <= wdata;
      end
   end
endmodule : ifa_apb_master

// ---- verification/ifa_add_unit_tb.sv ----
/*
 self-checking bench for the add-family unit: table of instructions, then
 rounding, exception, configuration and bus cases.
 assumes the register map and status layout of the unit's package.
*/
`timescale 1ns/1ps

module ifa_add_unit_tb;
   typedef struct packed {
      logic [31:0] insn;
      logic [63:0] a;
      logic [63:0] b;
      logic [2:0] x;
      logic [1:0] w;
      logic [4:0] d;
      logic [63:0] r;
   } ifa_row_s;

   localparam logic [2:0] xNo = ifa_pkg::EXC_NONE;
   localparam logic [2:0] xOv = ifa_pkg::EXC_INT_OVF;
   localparam logic [2:0] xRs = ifa_pkg::EXC_RESERVED;
   localparam logic [2:0] xUn = ifa_pkg::EXC_UNUSABLE;
   localparam logic [2:0] xFl = ifa_pkg::EXC_FLOAT;

   logic clk = 1'b0;
   logic rst_n, start, wr, done, err, psel, penable, pwrite, pready, pslverr;
   logic [7:0] addr, paddr;
   logic [31:0] wdata, rdata, pwdata, prdata;
   logic [9:0] stat;
   logic [63:0] res;
   logic [31:0] rnd [4];
   ifa_row_s rows [16];
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;

   always #5 clk = ~clk;

   ifa_add_unit i_ifa_add_unit (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   ifa_apb_master i_ifa_apb_master (.clk(clk), .start(start), .wr(wr), .addr(addr),
      .wdata(wdata), .done(done), .rdata(rdata), .err(err), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   function automatic logic [31:0] rIns(input logic [5:0] fn, input logic [4:0] sh,
                                        input logic [4:0] rd);
      return {ifa_pkg::OP_SPECIAL, 5'h01, 5'h02, rd, sh, fn};
   endfunction : rIns

   function automatic logic [31:0] iIns(input logic [5:0] op, input logic [15:0] imm);
      return {op, 5'h01, 5'h04, imm};
   endfunction : iIns

   function automatic logic [31:0] fIns(input logic [4:0] fmt);
      return {ifa_pkg::OP_FLOAT, fmt, 5'h02, 5'h01, 5'h05, ifa_pkg::FN_FSUM};
   endfunction : fIns

   function automatic logic [31:0] pIns(input logic [1:0] mn, input logic [18:0] imm);
      return {ifa_pkg::OP_PC_REL, 5'h01, mn, imm};
   endfunction : pIns

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      start <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      start <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (done !== 1'b1 && n < 10);
      if (done !== 1'b1) begin
         chk("bus answer", 64'h1, 64'h0);
      end
   endtask : bus

   task automatic run(input logic [31:0] insn, input logic [63:0] a, input logic [63:0] b);
      bus(1'b1, ifa_pkg::ADDR_A_LO, a[31:0]);
      bus(1'b1, ifa_pkg::ADDR_A_HI, a[63:32]);
      bus(1'b1, ifa_pkg::ADDR_B_LO, b[31:0]);
      bus(1'b1, ifa_pkg::ADDR_B_HI, b[63:32]);
      bus(1'b1, ifa_pkg::ADDR_INSN, insn);
      bus(1'b0, ifa_pkg::ADDR_STAT, 32'h0);
      stat = rdata[9:0];
      bus(1'b0, ifa_pkg::ADDR_RES_LO, 32'h0);
      res[31:0] = rdata;
      bus(1'b0, ifa_pkg::ADDR_RES_HI, 32'h0);
      res[63:32] = rdata;
   endtask : run

   task automatic want(input string n, input logic [2:0] x, input logic [1:0] w,
                       input logic [4:0] d, input logic [63:0] r);
      chk({n, " status"}, {59'h0, x, w}, {59'h0, stat[4:0]});
      if (w != 2'h0) begin
         chk({n, " dst"}, {59'h0, d}, {59'h0, stat[9:5]});
      end
      chk({n, " result"}, r, res);
   endtask : want

   task automatic fcs(input string n, input logic [31:0] e);
      bus(1'b0, ifa_pkg::ADDR_FCS, 32'h0);
      chk(n, {32'h0, e}, {32'h0, rdata});
   endtask : fcs

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         num_errors++;
         conclude();
      end
   end

   initial begin
      rst_n = 1'b0;
      start = 1'b0;
      wr = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      rnd = '{32'h3f800000, 32'h3f800000, 32'h3f800001, 32'h3f800000};
      rows = '{ // operands sign-extended, formats matched
         '{rIns(6'h20, 5'h0, 5'h3), 64'h7ffffff0, 64'hf, xNo, 2'h1, 5'h3, 64'h7fffffff},
         '{rIns(6'h20, 5'h0, 5'h3), 64'h7fffffff, 64'h1, xOv, 2'h0, 5'h3, 64'h7fffffff},
         '{rIns(6'h20, 5'h0, 5'h3), 64'hffffffff80000000, '1, xOv, 2'h0, 5'h3, 64'h7fffffff},
         '{rIns(6'h20, 5'h0, 5'h3), 64'hfffffffffffffffe, 64'h1, xNo, 2'h1, 5'h3, '1},
         '{rIns(6'h20, 5'h1, 5'h3), 64'h1, 64'h1, xRs, 2'h0, 5'h3, '1},
         '{rIns(6'h21, 5'h0, 5'h6), 64'h7fffffff, 64'h1, xNo, 2'h1, 5'h6, 64'hffffffff80000000},
         '{iIns(6'h08, 16'h0001), 64'h7fffffff, 64'h0, xOv, 2'h0, 5'h4, 64'hffffffff80000000},
         '{iIns(6'h08, 16'h8000), 64'h0, 64'h0, xNo, 2'h1, 5'h4, 64'hffffffffffff8000},
         '{iIns(6'h09, 16'h0001), 64'h7fffffff, 64'h0, xNo, 2'h1, 5'h4, 64'hffffffff80000000},
         '{iIns(6'h09, 16'hffff), 64'hffffffff80000000, 64'h0, xNo, 2'h1, 5'h4, 64'h7fffffff},
         '{fIns(ifa_pkg::FMT_S), 64'h3f800000, 64'h40000000, xNo, 2'h2, 5'h5, 64'h40400000},
         '{fIns(ifa_pkg::FMT_D), 64'h3ff0000000000000, 64'h4000000000000000, xNo, 2'h2, 5'h5,
           64'h4008000000000000},
         '{fIns(ifa_pkg::FMT_PS), 64'h3f80000040000000, 64'h4000000040000000, xNo, 2'h2, 5'h5,
           64'h4040000040800000},
         '{fIns(5'h12), 64'h0, 64'h0, xRs, 2'h0, 5'h5, 64'h4040000040800000},
         '{pIns(2'h0, 19'h1), 64'h0, 64'h0, xRs, 2'h0, 5'h1, 64'h4040000040800000},
         '{fIns(ifa_pkg::FMT_S), 64'h7f800000, 64'hff800000, xNo, 2'h2, 5'h5, 64'h7fc00000}};
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, ifa_pkg::ADDR_CFG, 32'h0);
      chk("cfg reset", 64'he, {32'h0, rdata});
      fcs("fcs reset", 32'h0);
      bus(1'b0, ifa_pkg::ADDR_STAT, 32'h0);
      chk("stat reset", 64'h0, {32'h0, rdata});
      foreach (rows[i]) begin
         run(rows[i].insn, rows[i].a, rows[i].b);
         want("row", rows[i].x, rows[i].w, rows[i].d, rows[i].r);
      end
      fcs("fcs invalid", 32'h10040);
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, ifa_pkg::ADDR_FCS, 32'(m));
         run(fIns(ifa_pkg::FMT_S), 64'h3f800000, 64'h33800000);
         want("round", xNo, 2'h2, 5'h5, {32'h0, rnd[m]});
         fcs("round fcs", 32'h1004 + 32'(m));
      end
      bus(1'b1, ifa_pkg::ADDR_FCS, 32'h0);
      run(fIns(ifa_pkg::FMT_S), 64'h7f7fffff, 64'h7f7fffff);
      want("fovf", xNo, 2'h2, 5'h5, 64'h7f800000);
      fcs("fovf fcs", 32'h5014);
      bus(1'b1, ifa_pkg::ADDR_FCS, 32'h80);
      run(fIns(ifa_pkg::FMT_S), 64'h3f800000, 64'h33800000);
      want("ftrap", xFl, 2'h0, 5'h5, 64'h7f800000);
      fcs("ftrap fcs", 32'h1080);
      bus(1'b1, ifa_pkg::ADDR_FCS, 32'h0);
      bus(1'b1, ifa_pkg::ADDR_CFG, 32'hc);
      run(fIns(ifa_pkg::FMT_D), 64'h0, 64'h0);
      want("unusable", xUn, 2'h0, 5'h5, 64'h7f800000);
      bus(1'b1, ifa_pkg::ADDR_CFG, 32'hf);
      run(fIns(ifa_pkg::FMT_PS), 64'h0, 64'h0);
      want("rel6 paired", xRs, 2'h0, 5'h5, 64'h7f800000);
      run(iIns(6'h08, 16'h0001), 64'h1, 64'h0);
      want("rel6 imm", xRs, 2'h0, 5'h4, 64'h7f800000);
      bus(1'b1, ifa_pkg::ADDR_PC_LO, 32'h0);
      bus(1'b1, ifa_pkg::ADDR_PC_HI, 32'h1);
      run(pIns(2'h0, 19'h7ffff), 64'h0, 64'h0);
      want("pc sum", xNo, 2'h1, 5'h1, 64'hfffffffc);
      run(pIns(2'h1, 19'h1), 64'h0, 64'h0);
      want("pc minor", xRs, 2'h0, 5'h1, 64'hfffffffc);
      bus(1'b1, ifa_pkg::ADDR_CFG, 32'h7);
      run(pIns(2'h0, 19'h7ffff), 64'h0, 64'h0);
      want("pc sum32", xNo, 2'h1, 5'h1, 64'hfffffffffffffffc);
      bus(1'b1, ifa_pkg::ADDR_RES_LO, 32'h55);
      bus(1'b0, ifa_pkg::ADDR_RES_LO, 32'h0);
      chk("result ro", 64'hfffffffc, {32'h0, rdata});
      bus(1'b0, 8'h30, 32'h0);
      chk("unmapped", 64'h1_00000000, {31'h0, err, rdata});
      conclude();
   end
endmodule : ifa_add_unit_tb
